/* src/ddrlq_params.svh */
// Constants for the DDR latency query table: offsets, table bytes and counts
`ifndef DDRLQ_PARAMS_SVH
`define DDRLQ_PARAMS_SVH

// Parameter identifiers and lengths
`define DDRLQ_ID_LATENCY     8'h9A
`define DDRLQ_LEN_LATENCY    8'h2A
`define DDRLQ_ROW_COUNT      8'h05
`define DDRLQ_ROW_BYTES      8'h08
`define DDRLQ_ID_PAD         8'hF0
`define DDRLQ_LEN_PAD        8'h0F
`define DDRLQ_FILL           8'hFF

// Header row: column letters and the six DDR read opcodes
`define DDRLQ_HDR_FREQ       8'h46
`define DDRLQ_HDR_CODE       8'h43
`define DDRLQ_OP_FAST3       8'h0D
`define DDRLQ_OP_FAST4       8'h0E
`define DDRLQ_OP_DUAL3       8'hBD
`define DDRLQ_OP_DUAL4       8'hBE
`define DDRLQ_OP_QUAD3       8'hED
`define DDRLQ_OP_QUAD4       8'hEE

// Data rows: freq, code, fast mode/dummy, dual mode/dummy, quad mode/dummy
`define DDRLQ_ROW_50_C3      64'h3203_0401_0202_0103
`define DDRLQ_ROW_66_C0      64'h4200_0402_0204_0106
`define DDRLQ_ROW_66_C1      64'h4201_0404_0205_0107
`define DDRLQ_ROW_66_C2      64'h4202_0405_0206_0108

// Latency code values as held in the configuration register
`define DDRLQ_LC_00          2'b00
`define DDRLQ_LC_01          2'b01
`define DDRLQ_LC_10          2'b10
`define DDRLQ_LC_11          2'b11

// Query map layout, relative to the latency parameter start
`define DDRLQ_LAT_BYTES      9'd44
`define DDRLQ_PAD_BASE       8'h2C
`define DDRLQ_PAD_LAST       8'h3C
`define DDRLQ_ROW_W          7'd64

// Link framing
`define DDRLQ_BYTE_BITS      3'd7
`define DDRLQ_SYNC_STAGES    2

`endif

/* src/ddrlq_pkg.sv */
// Types shared by the DDR latency query table modules
package ddrlq_pkg;

  typedef logic [7:0]  ddrlq_byte_t;
  typedef logic [63:0] ddrlq_row_t;

  typedef enum logic [1:0] {
    DDRLQ_IDLE = 2'b00,
    DDRLQ_ADDR = 2'b01,
    DDRLQ_DATA = 2'b10
  } ddrlq_state_e;

endpackage

/* src/ddrlq_rom.sv */
// Fixed query bytes of the DDR latency and padding parameters, plus row select
`timescale 1ns/1ps
`include "ddrlq_params.svh"

module ddrlq_rom
  import ddrlq_pkg::*;
(
  input  wire ddrlq_byte_t addr,
  input  wire logic [1:0]  lat_code,
  output ddrlq_byte_t      data,
  output ddrlq_row_t       row
);

  // Whole latency parameter, byte 00h in the top lane
  localparam logic [351:0] LAT_TBL = {
    `DDRLQ_ID_LATENCY, `DDRLQ_LEN_LATENCY, `DDRLQ_ROW_COUNT, `DDRLQ_ROW_BYTES,
    `DDRLQ_HDR_FREQ, `DDRLQ_HDR_CODE,
    `DDRLQ_OP_FAST3, `DDRLQ_OP_FAST4,
    `DDRLQ_OP_DUAL3, `DDRLQ_OP_DUAL4,
    `DDRLQ_OP_QUAD3, `DDRLQ_OP_QUAD4,
    `DDRLQ_ROW_50_C3, `DDRLQ_ROW_66_C0,
    `DDRLQ_ROW_66_C1, `DDRLQ_ROW_66_C2
  };

  // Lane select; constant content, array contents never reach here
  wire logic        in_lat  = {1'b0, addr} < `DDRLQ_LAT_BYTES;
  wire logic [8:0]  lat_pos = 9'(11'd351 - {addr, 3'b000});
  wire ddrlq_byte_t lat_byte = LAT_TBL[lat_pos -: 8];
  wire logic        is_pad_id  = addr == `DDRLQ_PAD_BASE;
  wire logic        is_pad_len = addr == (`DDRLQ_PAD_BASE + 8'h01);

  // Query byte: latency table, then padding parameter, FFh elsewhere
  assign data = in_lat     ? lat_byte :
                is_pad_id  ? `DDRLQ_ID_PAD :
                is_pad_len ? `DDRLQ_LEN_PAD :
                `DDRLQ_FILL;

  // Row picked by latency code; code 11b is the 50 MHz row
  assign row = (lat_code == `DDRLQ_LC_11) ? `DDRLQ_ROW_50_C3 :
               (lat_code == `DDRLQ_LC_00) ? `DDRLQ_ROW_66_C0 :
               (lat_code == `DDRLQ_LC_01) ? `DDRLQ_ROW_66_C1 :
               `DDRLQ_ROW_66_C2;

endmodule

/* src/ddrlq_top.sv */
// Serial query port for the DDR latency table, with active latency outputs
//
// Function
// - The latency parameter starts with ID 9Ah and declares five rows of eight bytes.
// - Byte 01h holds 2Ah, the count of following bytes, so the next parameter is found.
// - The header row opens with ASCII F (46h) and ASCII C (43h).
// - The header lists fast DDR read opcodes 0Dh and 0Eh.
// - The header lists dual-I/O DDR read opcodes BDh and BEh.
// - The header lists quad-I/O DDR read opcodes EDh and EEh.
// - Code 11b up to 50 MHz gives fast 4/1, dual 2/2, quad 1/3 mode/dummy cycles.
// - Code 00b up to 66 MHz gives fast 4/2, dual 2/4, quad 1/6 mode/dummy cycles.
// - Code 01b up to 66 MHz gives fast 4/4, dual 2/5, quad 1/7 mode/dummy cycles.
// - Code 10b up to 66 MHz gives fast 4/5, dual 2/6, quad 1/8 mode/dummy cycles.
// - The padding parameter has ID F0h, length 0Fh, and FFh up to offset 10h.
// - Padding may repeat with other lengths and a host skips it by its length byte.
// - Configuration bits 7 and 6 form the latency code that picks a table row; here pins LATENCY_SELECT_HIGH and LATENCY_SELECT_LOW supply it.
`timescale 1ns/1ps
`include "ddrlq_params.svh"

module ddrlq_top
  import ddrlq_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic       SI,
  input  wire logic       LATENCY_SELECT_HIGH,
  input  wire logic       LATENCY_SELECT_LOW,
  output logic            SO,
  output logic            SO_OE,
  output logic [7:0]      FREQ_LIMIT,
  output logic [1:0]      LATENCY_CODE,
  output logic [7:0]      FAST_MODE_CYC,
  output logic [7:0]      FAST_DUMMY_CYC,
  output logic [7:0]      DUAL_MODE_CYC,
  output logic [7:0]      DUAL_DUMMY_CYC,
  output logic [7:0]      QUAD_MODE_CYC,
  output logic [7:0]      QUAD_DUMMY_CYC
);

  // Synchroniser stages; stage 0 is read only by stage 1
  logic [1:0]   cs_sync;
  logic [1:0]   sck_sync;
  logic [1:0]   si_sync;
  logic [1:0]   lch_sync;
  logic [1:0]   lcl_sync;
  logic         sck_prev;

  // Frame state
  ddrlq_state_e state;
  ddrlq_state_e next_state;
  ddrlq_byte_t  addr;
  ddrlq_byte_t  next_addr;
  logic [2:0]   bit_cnt;
  logic [2:0]   next_bit_cnt;
  logic         next_so;
  logic         next_so_oe;

  // Table lookup results
  ddrlq_byte_t  rom_data;
  ddrlq_row_t   rom_row;

  // Two flops on every pin except RST; the link clock is just another sampled pin
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cs_sync  <= 2'b11;
      sck_sync <= 2'b00;
      si_sync  <= 2'b00;
      lch_sync <= 2'b00;
      lcl_sync <= 2'b00;
      sck_prev <= 1'b0;
    end else begin
      cs_sync  <= {cs_sync[0], CS_N};
      sck_sync <= {sck_sync[0], SCK};
      si_sync  <= {si_sync[0], SI};
      lch_sync <= {lch_sync[0], LATENCY_SELECT_HIGH};
      lcl_sync <= {lcl_sync[0], LATENCY_SELECT_LOW};
      sck_prev <= sck_sync[1];
    end
  end

  // Edge and level decode from the settled stages only
  wire logic       cs_act   = ~cs_sync[1];
  wire logic       sck_rise = sck_sync[1] & ~sck_prev;
  wire logic       sck_fall = ~sck_sync[1] & sck_prev;
  wire logic       si_bit   = si_sync[1];
  wire logic [1:0] lat_code = {lch_sync[1], lcl_sync[1]};
  wire logic       last_bit = bit_cnt == `DDRLQ_BYTE_BITS;

  // Constant content and latency row lookup
  ddrlq_rom u_rom (
    .addr     (addr),
    .lat_code (lat_code),
    .data     (rom_data),
    .row      (rom_row)
  );

  // Bit of the current byte to shift out, MSB first
  wire logic [2:0] out_idx = 3'(`DDRLQ_BYTE_BITS - bit_cnt);
  wire logic       out_bit = rom_data[out_idx];

  // Frame sequencer: one address byte in, then bytes out until deselect
  always_comb begin
    next_state   = state;
    next_addr    = addr;
    next_bit_cnt = bit_cnt;
    next_so      = SO;
    next_so_oe   = SO_OE;
    if (!cs_act) begin
      // Deselect ends the frame at once, whatever the bit position
      next_state   = DDRLQ_IDLE;
      next_bit_cnt = 3'd0;
      next_so_oe   = 1'b0;
      next_so      = 1'b0;
    end else begin
      case (state)
        DDRLQ_IDLE: begin
          next_state   = DDRLQ_ADDR;
          next_bit_cnt = 3'd0;
        end
        DDRLQ_ADDR: begin
          if (sck_rise) begin
            next_addr    = {addr[6:0], si_bit};
            next_bit_cnt = bit_cnt + 3'd1;
            if (last_bit) begin
              next_state = DDRLQ_DATA;
            end
          end
        end
        DDRLQ_DATA: begin
          // Drive on the falling edge so the host samples on the rising one
          if (sck_fall) begin
            next_so      = out_bit;
            next_so_oe   = 1'b1;
            next_bit_cnt = bit_cnt + 3'd1;
            if (last_bit) begin
              next_addr = addr + 8'h01;  // Sequential read, wraps at FFh
            end
          end
        end
        default: begin
          next_state = DDRLQ_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state   <= DDRLQ_IDLE;
      addr    <= 8'h00;
      bit_cnt <= 3'd0;
      SO      <= 1'b0;
      SO_OE   <= 1'b0;
    end else begin
      state   <= next_state;
      addr    <= next_addr;
      bit_cnt <= next_bit_cnt;
      SO      <= next_so;
      SO_OE   <= next_so_oe;
    end
  end

  // Active row fields, registered so outputs come from flops
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FREQ_LIMIT     <= 8'h00;
      LATENCY_CODE   <= 2'b00;
      FAST_MODE_CYC  <= 8'h00;
      FAST_DUMMY_CYC <= 8'h00;
      DUAL_MODE_CYC  <= 8'h00;
      DUAL_DUMMY_CYC <= 8'h00;
      QUAD_MODE_CYC  <= 8'h00;
      QUAD_DUMMY_CYC <= 8'h00;
    end else begin
      FREQ_LIMIT     <= rom_row[63:56];
      LATENCY_CODE   <= rom_row[49:48];
      FAST_MODE_CYC  <= rom_row[47:40];
      FAST_DUMMY_CYC <= rom_row[39:32];
      DUAL_MODE_CYC  <= rom_row[31:24];
      DUAL_DUMMY_CYC <= rom_row[23:16];
      QUAD_MODE_CYC  <= rom_row[15:8];
      QUAD_DUMMY_CYC <= rom_row[7:0];
    end
  end

endmodule

/* verification/ddrlq_asserts.sv */
// Port checker for the DDR latency query table
`timescale 1ns/1ps
module ddrlq_asserts (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       LATENCY_SELECT_HIGH,
  input wire logic       LATENCY_SELECT_LOW,
  input wire logic       SO_OE,
  input wire logic [7:0] FREQ_LIMIT,
  input wire logic [1:0] LATENCY_CODE,
  input wire logic [7:0] FAST_MODE_CYC,
  input wire logic [7:0] FAST_DUMMY_CYC,
  input wire logic [7:0] DUAL_MODE_CYC,
  input wire logic [7:0] DUAL_DUMMY_CYC,
  input wire logic [7:0] QUAD_MODE_CYC,
  input wire logic [7:0] QUAD_DUMMY_CYC
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Whole selected row; five stable samples cover sync and output flops
  wire [57:0] row = {FREQ_LIMIT, LATENCY_CODE, FAST_MODE_CYC, FAST_DUMMY_CYC,
                     DUAL_MODE_CYC, DUAL_DUMMY_CYC, QUAD_MODE_CYC, QUAD_DUMMY_CYC};
  sequence s_sel(logic [1:0] c);
    ({LATENCY_SELECT_HIGH, LATENCY_SELECT_LOW} == c)[*5];
  endsequence
  property p_c3; s_sel(2'b11) |-> row == 58'h0CB_0401_0202_0103; endproperty
  a_c3: assert property (p_c3) else $error("row code 11");
  property p_c0; s_sel(2'b00) |-> row == 58'h108_0402_0204_0106; endproperty
  a_c0: assert property (p_c0) else $error("row code 00");
  property p_c1; s_sel(2'b01) |-> row == 58'h109_0404_0205_0107; endproperty
  a_c1: assert property (p_c1) else $error("row code 01");
  property p_c2; s_sel(2'b10) |-> row == 58'h10A_0405_0206_0108; endproperty
  a_c2: assert property (p_c2) else $error("row code 10");
  // Limit byte must agree with the code it is shown beside
  property p_freq;
    FREQ_LIMIT != 8'h00 |-> FREQ_LIMIT == ((LATENCY_CODE == 2'b11) ? 8'h32 : 8'h42);
  endproperty
  a_freq: assert property (p_freq) else $error("limit vs code");
  property p_mode;
    FAST_MODE_CYC != 8'h00 |-> {FAST_MODE_CYC, DUAL_MODE_CYC, QUAD_MODE_CYC} == 24'h04_0201;
  endproperty
  a_mode: assert property (p_mode) else $error("mode counts");
  property p_oe_sel; $rose(SO_OE) |-> !CS_N; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("drive unselected");
  property p_oe_idle; CS_N[*5] |-> !SO_OE; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive when idle");
endmodule

bind ddrlq_top ddrlq_asserts u_asserts (.CLK_SYS, .RST, .CS_N, .LATENCY_SELECT_HIGH,
  .LATENCY_SELECT_LOW, .SO_OE, .FREQ_LIMIT, .LATENCY_CODE, .FAST_MODE_CYC,
  .FAST_DUMMY_CYC, .DUAL_MODE_CYC, .DUAL_DUMMY_CYC, .QUAD_MODE_CYC, .QUAD_DUMMY_CYC);

/* verification/ddrlq_host.sv */
// Host model: serial query reader with optional slow byte gaps
`timescale 1ns/1ps
module ddrlq_host (
  input  wire logic CLK_SYS,
  input  wire logic SO,
  input  wire logic SO_OE,
  output logic      CS_N,
  output logic      SCK,
  output logic      SI
);
  logic [7:0] rd [0:63];
  logic       oe_bad = 1'b0;
  int         gap = 0;
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    SI = 1'b0;
  end
  // Half link period; changes land just after the system edge
  task automatic half();
    repeat (4) @(posedge CLK_SYS);
    #1;
  endtask
  // Address byte MSB first, then n whole bytes; SO taken late in the high phase
  task automatic frame(input logic [7:0] a, input int n);
    int i;
    CS_N = 1'b0;
    half();
    for (i = 0; i < 8 + 8 * n; i++) begin
      if (i < 8) SI = a[7 - i];
      else SI = ~SI; // Unused input toggles, never a stale bit
      if (i >= 8 && i % 8 == 0) repeat (gap) @(posedge CLK_SYS);
      half();
      SCK = 1'b1;
      half();
      if (i >= 8) rd[(i - 8) / 8][7 - i % 8] = SO;
      if (i >= 8 && SO_OE !== 1'b1) oe_bad = 1'b1;
      SCK = 1'b0;
    end
    half();
    CS_N = 1'b1;
    repeat (2) half(); // Long enough deselect to see the output released
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the DDR latency query table
`timescale 1ns/1ps
module testbench;
  logic clk, rst, sel_hi, sel_lo, cs_n, sck, si, so, so_oe;
  logic [7:0] freq, fm, fd, dm, dd, qm, qd, a, nxt;
  logic [1:0] code;
  int errors = 0, check_count = 0, seed = 58459, i, n;
  wire [63:0] row = {freq, 6'h00, code, fm, fd, dm, dd, qm, qd};
  ddrlq_top DUT (.CLK_SYS(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si),
    .LATENCY_SELECT_HIGH(sel_hi), .LATENCY_SELECT_LOW(sel_lo), .SO(so), .SO_OE(so_oe),
    .FREQ_LIMIT(freq), .LATENCY_CODE(code), .FAST_MODE_CYC(fm), .FAST_DUMMY_CYC(fd),
    .DUAL_MODE_CYC(dm), .DUAL_DUMMY_CYC(dd), .QUAD_MODE_CYC(qm), .QUAD_DUMMY_CYC(qd));
  ddrlq_host host (.CLK_SYS(clk), .SO(so), .SO_OE(so_oe), .CS_N(cs_n), .SCK(sck), .SI(si));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Expected row: limit, code, then mode/dummy pairs fast, dual, quad
  function automatic logic [63:0] exp_row(input logic [1:0] c);
    case (c)
      2'b11: exp_row = 64'h3203_0401_0202_0103;
      2'b00: exp_row = 64'h4200_0402_0204_0106;
      2'b01: exp_row = 64'h4201_0404_0205_0107;
      default: exp_row = 64'h4202_0405_0206_0108;
    endcase
  endfunction
  // Query map: latency parameter, padding right after, blank beyond
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    logic [351:0] m;
    m = {96'h9A2A_0508_4643_0D0E_BDBE_EDEE, exp_row(2'b11), exp_row(2'b00),
         exp_row(2'b01), exp_row(2'b10)};
    if (a < 8'h2C) exp_byte = m[351 - 8 * a -: 8];
    else if (a == 8'h2C) exp_byte = 8'hF0;
    else if (a == 8'h2D) exp_byte = 8'h0F;
    else exp_byte = 8'hFF;
  endfunction
  // Hang guard, well past the expected run length
  initial begin
    #1_600_000;
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    // Every code in turn, then random codes
    for (i = 0; i < 12; i++) begin
      {sel_hi, sel_lo} = (i < 4) ? i[1:0] : 2'($random(seed));
      repeat (6) @(posedge clk);
      #1 chk(row, exp_row({sel_hi, sel_lo}));
    end
    host.frame(8'h00, 64);
    for (i = 0; i < 64; i++) chk(host.rd[i], exp_byte(i[7:0]));
    // Walk parameters by their length bytes, as a host would
    host.frame(8'h01, 1);
    nxt = 8'h02 + host.rd[0];
    host.frame(nxt, 2);
    chk(host.rd[0], 8'hF0);
    nxt = nxt + 8'h02 + host.rd[1];
    host.frame(nxt, 1);
    chk(host.rd[0], 8'hFF);
    // Random bursts, first one from FEh, wrapping past the top address when n is 3 or 4, with slow hosts
    for (i = 0; i < 20; i++) begin
      a = (i == 0) ? 8'hFE : 8'($random(seed));
      n = 1 + ($random(seed) & 3);
      host.gap = $random(seed) & 7;
      host.frame(a, n);
      for (int k = 0; k < n; k++) chk(host.rd[k], exp_byte(a + k[7:0]));
    end
    chk(host.oe_bad, 1'b0);
    // Reset in mid-run clears outputs, then the row comes back
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({so_oe, freq}, 9'h000);
    rst = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(row, exp_row({sel_hi, sel_lo}));
    report_and_stop();
  end
endmodule
